// >>> design/rrir_pkg.sv
// Package with register offsets, reset values and gain-table constants for the result bank.
package rrir_pkg;

	// ----------------------------------------------------------------
	// Register offsets.
	// ----------------------------------------------------------------
	localparam logic [7:0] RRIR_OFS_DATA_FIRST = 8'h02; // First processed result byte.
	localparam logic [7:0] RRIR_OFS_DATA_LAST = 8'h09; // Last processed result byte.
	localparam logic [7:0] RRIR_OFS_CH0_LOW = 8'h59; // Channel zero bits 7:0.
	localparam logic [7:0] RRIR_OFS_CH0_MID = 8'h5A; // Channel zero bits 15:8.
	localparam logic [7:0] RRIR_OFS_CH0_HIGH = 8'h5B; // Channel zero bits 23:16.
	localparam logic [7:0] RRIR_OFS_CH2_HIGH = 8'h61; // Channel two bits 23:16.
	localparam logic [7:0] RRIR_OFS_CH3_LOW = 8'h62; // Channel three bits 7:0.
	localparam logic [7:0] RRIR_OFS_CH3_MID = 8'h63; // Channel three bits 15:8.
	localparam logic [7:0] RRIR_OFS_CH3_HIGH = 8'h64; // Channel three bits 23:16.
	localparam logic [7:0] RRIR_OFS_MAKER_LOW = 8'hFC; // Maker code low byte.
	localparam logic [7:0] RRIR_OFS_MAKER_HIGH = 8'hFD; // Maker code high byte.
	localparam logic [7:0] RRIR_OFS_PART_LOW = 8'hFE; // Part code low byte.
	localparam logic [7:0] RRIR_OFS_PART_HIGH = 8'hFF; // Part code high byte.

	// ----------------------------------------------------------------
	// Reset values and field layout.
	// ----------------------------------------------------------------
	localparam logic [7:0] RRIR_RST_BYTE = 8'h00; // Raw and result bytes clear at reset.
	localparam logic [23:0] RRIR_RST_RAW = 24'h000000; // Whole raw word clear at reset.
	localparam int RRIR_RAW_W = 24; // Raw measurement width.
	localparam int RRIR_CODE_W = 6; // Gain code width.
	localparam int RRIR_GRP_LSB = 3; // Gain code group field starts here.
	localparam logic [2:0] RRIR_STEP_ONE = 3'h1; // Code offset giving the one-sixteenth step.

	// Gain factor in fixed point, 8 integer bits and 4 fraction bits.
	localparam int RRIR_GAIN_W = 12; // Width of the gain factor.
	localparam int RRIR_GAIN_FRAC = 4; // Fraction bits of the gain factor.
	localparam logic [11:0] RRIR_GAIN_ONE = 12'h010; // Factor 1.0 in fixed point.

endpackage : rrir_pkg

// >>> design/rrir_top.sv
// Read-only raw result and identification register bank with gain-code decoder.
`timescale 1ns/100ps

module rrir_top
	import rrir_pkg::*;
#(
	parameter logic [15:0] MAKER_CODE = 16'hA5C3, // Arbitrary value, not a real maker code.
	parameter logic [15:0] PART_CODE = 16'h1234 // Arbitrary value, not a real part code.
) (
	input wire logic CLK_I, // 200 MHz system clock.
	input wire logic RESET_N_I, // Asynchronous reset, active low.
	input wire logic CE_I, // Clock enable; all state holds while low.
	input wire logic [7:0] REG_ADDR_I, // Register offset from the serial port.
	input wire logic REG_RD_I, // Read strobe, one cycle.
	output logic [7:0] REG_RDATA_O, // Read data, registered.
	output logic REG_RVALID_O, // Read data valid, one-cycle pulse.
	input wire logic RAW_UPD_I, // Engine strobe: new raw words are valid.
	input wire logic [23:0] CH0_RAW_I, // Channel zero unprocessed value.
	input wire logic [23:0] CH2_RAW_I, // Channel two unprocessed value.
	input wire logic [23:0] CH3_RAW_I, // Channel three unprocessed value.
	input wire logic DATA_UPD_I, // Engine strobe: new processed results valid.
	input wire logic [63:0] DATA_I, // Processed results, byte 0 for 0x02.
	input wire logic [5:0] GAIN_CODE_I, // Channel amplification code to decode.
	output logic [11:0] GAIN_FACTOR_O // Decoded gain, 8.4 fixed point, registered.
);

	// ----------------------------------------------------------------
	// Stored measurement values.
	// ----------------------------------------------------------------
	logic [23:0] ch0_unprocessed_value_reg; // Channel zero raw word.
	logic [23:0] ch2_unprocessed_value_reg; // Channel two raw word.
	logic [23:0] ch3_unprocessed_value_reg; // Channel three raw word.
	logic [63:0] processed_channel_result_reg; // Eight processed result bytes.
	logic [23:0] snap_reg; // Burst snapshot of one raw word.
	logic [7:0] rdata_next; // Read data before the output flop.
	logic [11:0] gain_next; // Decoded gain before the output flop.

	// ----------------------------------------------------------------
	// Measurement capture.
	// ----------------------------------------------------------------
	// The engine hands over all three raw words in one strobe. Loading them
	// together means a host that reads channel zero and then channel three
	// sees words of the same scan, unless a strobe falls between the reads.
	// Raw words load together on the engine strobe so the three stored words always come from one scan.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			ch0_unprocessed_value_reg <= RRIR_RST_RAW;
			ch2_unprocessed_value_reg <= RRIR_RST_RAW;
			ch3_unprocessed_value_reg <= RRIR_RST_RAW;
		end else if (CE_I && RAW_UPD_I) begin
			ch0_unprocessed_value_reg <= CH0_RAW_I;
			ch2_unprocessed_value_reg <= CH2_RAW_I;
			ch3_unprocessed_value_reg <= CH3_RAW_I;
		end
	end

	// Processed results arrive as one block from the engine.
	// Byte n of the block answers at the first result offset plus n, so
	// the engine can hand over all eight results without an address.
	// A host may see results of two scans if a strobe falls inside its reads.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			// Every result byte clears to the common byte reset value.
			processed_channel_result_reg <= {8{RRIR_RST_BYTE}};
		end else if (CE_I && DATA_UPD_I) begin
			processed_channel_result_reg <= DATA_I;
		end
	end

	// A read of a channel's low byte freezes that word, so the mid and high
	// bytes read afterwards belong to the same conversion as the low byte.
	// Channel two's low bytes are outside this bank, so its high byte reads live.
	// Limitation: a mid or high read with no low read before it returns the
	// last snapshot, which is zero after reset. The register costs 24 flops
	// but spares the engine from stalling its updates while a host is busy.
	// Only one snapshot exists, so interleaved bursts of two channels mix up.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			snap_reg <= RRIR_RST_RAW;
		end else if (CE_I && REG_RD_I) begin
			if (REG_ADDR_I == RRIR_OFS_CH0_LOW) begin
				snap_reg <= ch0_unprocessed_value_reg;
			end else if (REG_ADDR_I == RRIR_OFS_CH3_LOW) begin
				snap_reg <= ch3_unprocessed_value_reg;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read decode.
	// ----------------------------------------------------------------
	// Unmapped offsets read as zero; writes do not exist on this bank.
	// The decode is purely combinational from the offset; only the output
	// flop below is clocked, so the answer always lands one edge after the
	// strobe whatever the offset.
	// Low raw bytes read the live word; the snapshot taken on the same edge
	// keeps the matching upper bytes for the rest of the burst.
	always_comb begin
		rdata_next = RRIR_RST_BYTE;
		if (REG_ADDR_I >= RRIR_OFS_DATA_FIRST && REG_ADDR_I <= RRIR_OFS_DATA_LAST) begin
			rdata_next = processed_channel_result_reg[8*(REG_ADDR_I - RRIR_OFS_DATA_FIRST) +: 8];
		end else begin
			case (REG_ADDR_I)
				RRIR_OFS_CH0_LOW: rdata_next = ch0_unprocessed_value_reg[7:0];
				RRIR_OFS_CH0_MID: rdata_next = snap_reg[15:8];
				RRIR_OFS_CH0_HIGH: rdata_next = snap_reg[23:16];
				RRIR_OFS_CH2_HIGH: rdata_next = ch2_unprocessed_value_reg[23:16];
				RRIR_OFS_CH3_LOW: rdata_next = ch3_unprocessed_value_reg[7:0];
				RRIR_OFS_CH3_MID: rdata_next = snap_reg[15:8];
				RRIR_OFS_CH3_HIGH: rdata_next = snap_reg[23:16];
				RRIR_OFS_MAKER_LOW: rdata_next = MAKER_CODE[7:0];
				RRIR_OFS_MAKER_HIGH: rdata_next = MAKER_CODE[15:8];
				RRIR_OFS_PART_LOW: rdata_next = PART_CODE[7:0];
				RRIR_OFS_PART_HIGH: rdata_next = PART_CODE[15:8];
				default: rdata_next = RRIR_RST_BYTE;
			endcase
		end
	end

	// Read data is registered one cycle after the strobe.
	// The valid flag follows the strobe on every enabled edge, so it pulses
	// once per byte. The data flop only moves on a taken read, which keeps
	// the last answer on the port for a host that samples late.
	// With the clock enable low both outputs hold, the valid flag included.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			REG_RDATA_O <= RRIR_RST_BYTE;
			REG_RVALID_O <= 1'b0;
		end else if (CE_I) begin
			REG_RVALID_O <= REG_RD_I;
			if (REG_RD_I) begin
				REG_RDATA_O <= rdata_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Gain code decoder.
	// ----------------------------------------------------------------
	// Base is two to the group index. Code offset 0 gives the base, offset 1
	// adds base/16, each further step adds base/8: base*(1 + (2k-1)/16).
	// Four fraction bits hold every factor exactly: the finest step is one
	// sixteenth at group zero, and the top factor 232 still fits in eight
	// integer bits. No rounding happens anywhere in the table.
	always_comb begin
		logic [2:0] grp;
		logic [2:0] ofs;
		logic [11:0] base;
		logic [11:0] step;
		grp = GAIN_CODE_I[RRIR_CODE_W-1:RRIR_GRP_LSB];
		ofs = GAIN_CODE_I[RRIR_GRP_LSB-1:0];
		base = RRIR_GAIN_ONE << grp;
		step = base >> RRIR_GAIN_FRAC;
		gain_next = base;
		if (ofs != 3'h0) begin
			gain_next = 12'(base + step * 12'({ofs, 1'b0} - {3'h0, RRIR_STEP_ONE}));
		end
	end

	// The decoded gain is registered on every enabled edge, one cycle behind
	// the code. Reset shows factor 1.0, the value of code zero.
	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			GAIN_FACTOR_O <= RRIR_GAIN_ONE;
		end else if (CE_I) begin
			GAIN_FACTOR_O <= gain_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	// Each read check looks one edge after a taken strobe, when the answer
	// stands on the port. Burst checks chain the taken strobes of one burst
	// and compare against the raw word as it stood at the low byte's edge.
	ch2_high_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH2_HIGH
		|=> REG_RDATA_O == $past(ch2_unprocessed_value_reg[23:16]) && REG_RVALID_O)
		else $error("Channel two high byte read wrong.");

	ch3_low_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_LOW
		|=> REG_RDATA_O == $past(ch3_unprocessed_value_reg[7:0]))
		else $error("Channel three low byte read wrong.");

	maker_code_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_MAKER_HIGH
		|=> REG_RDATA_O == MAKER_CODE[15:8])
		else $error("Maker code high byte wrong.");

	part_code_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_PART_LOW
		|=> REG_RDATA_O == PART_CODE[7:0])
		else $error("Part code low byte wrong.");

	gain_top_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && GAIN_CODE_I == 6'h3F |=> GAIN_FACTOR_O == 12'hE80)
		else $error("Top gain code not 232.");

	gain_group_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && GAIN_CODE_I[2:0] == 3'h0
		|=> GAIN_FACTOR_O == (RRIR_GAIN_ONE << $past(GAIN_CODE_I[5:3])))
		else $error("Group gain not a power of two.");

	result_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_DATA_LAST
		|=> REG_RDATA_O == $past(processed_channel_result_reg[63:56]))
		else $error("Last result byte wrong.");

	ch0_burst_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_LOW
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_MID
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_HIGH
		|=> REG_RDATA_O == $past(ch0_unprocessed_value_reg[23:16], 3))
		else $error("Channel zero burst not coherent.");

	// Further burst and single-byte read checks. A burst that sees a new
	// engine word after its low read must still answer with the old word.
	ch3_mid_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_LOW
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_MID
		|=> REG_RDATA_O == $past(ch3_unprocessed_value_reg[15:8], 2))
		else $error("Channel three middle byte read wrong.");

	ch3_high_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_LOW
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_MID
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH3_HIGH
		|=> REG_RDATA_O == $past(ch3_unprocessed_value_reg[23:16], 3))
		else $error("Channel three high byte read wrong.");

	ch0_low_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_LOW
		|=> REG_RDATA_O == $past(ch0_unprocessed_value_reg[7:0]))
		else $error("Channel zero low byte read wrong.");

	ch0_mid_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_LOW
		##1 CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_CH0_MID
		|=> REG_RDATA_O == $past(ch0_unprocessed_value_reg[15:8], 2))
		else $error("Channel zero middle byte read wrong.");

	maker_low_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_MAKER_LOW
		|=> REG_RDATA_O == MAKER_CODE[7:0])
		else $error("Maker code low byte wrong.");

	part_high_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_PART_HIGH
		|=> REG_RDATA_O == PART_CODE[15:8])
		else $error("Part code high byte wrong.");

	result_first_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == RRIR_OFS_DATA_FIRST
		|=> REG_RDATA_O == $past(processed_channel_result_reg[7:0]))
		else $error("First result byte wrong.");

	unmapped_read_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I && REG_ADDR_I == 8'(RRIR_OFS_DATA_LAST + 8'h01)
		|=> REG_RDATA_O == RRIR_RST_BYTE)
		else $error("Offset past the results not zero.");

	// Gain decoder checks, built from the factor one value and not from the
	// decoder's own step arithmetic.
	gain_zero_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && GAIN_CODE_I == 6'h00
		|=> GAIN_FACTOR_O == RRIR_GAIN_ONE)
		else $error("Gain code zero not 1.0.");

	gain_first_step_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && GAIN_CODE_I[2:0] == 3'h1
		|=> GAIN_FACTOR_O == 12'((RRIR_GAIN_ONE + 12'h001) << $past(GAIN_CODE_I[5:3])))
		else $error("First step of a group not one sixteenth up.");

	// Read handshake and clock enable checks.
	valid_pulse_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && REG_RD_I
		|=> REG_RVALID_O)
		else $error("Taken read not answered.");

	valid_drop_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && !REG_RD_I
		|=> !REG_RVALID_O)
		else $error("Read valid without a strobe.");

	ce_freeze_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		!CE_I
		|=> $stable(REG_RDATA_O) && $stable(REG_RVALID_O) && $stable(GAIN_FACTOR_O))
		else $error("Outputs moved with the clock enable low.");

	// Engine load checks: each stored word is the one offered at the strobe.
	ch2_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && RAW_UPD_I
		|=> ch2_unprocessed_value_reg == $past(CH2_RAW_I))
		else $error("Channel two word not loaded.");

	ch3_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && RAW_UPD_I
		|=> ch3_unprocessed_value_reg == $past(CH3_RAW_I))
		else $error("Channel three word not loaded.");

	ch0_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && RAW_UPD_I
		|=> ch0_unprocessed_value_reg == $past(CH0_RAW_I))
		else $error("Channel zero word not loaded.");

	result_load_a: assert property (@(posedge CLK_I) disable iff (!RESET_N_I)
		CE_I && DATA_UPD_I
		|=> processed_channel_result_reg == $past(DATA_I))
		else $error("Processed results not loaded.");

endmodule : rrir_top

// >>> sim/rrir_host.sv
// Host model that reads the result bank over its register port.
`timescale 1ns/100ps

module rrir_host (
	input wire logic clk_i, // System clock.
	input wire logic rvalid_i, // Read data valid.
	input wire logic [7:0] rdata_i, // Read data.
	output logic [7:0] addr_o, // Register offset.
	output logic rd_o // Read strobe.
);
	// Idle bus from time zero.
	initial begin
		addr_o = 8'h00;
		rd_o = 1'b0;
	end

	// Back-to-back reads of n bytes from a, packed low byte first.
	// ok drops if any answer is missed.
	// After the burst the offset flips so a stale address is never trusted.
	task automatic rd(input logic [7:0] a, input int n, output logic [23:0] v, output logic ok);
		v = 24'h000000;
		ok = 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			rd_o <= (i < n - 1);
			addr_o <= (i < n - 1) ? addr_o + 8'h01 : ~addr_o;
			#1;
			if (rvalid_i !== 1'b1) ok = 1'b0;
			v[8*i +: 8] = rdata_i;
		end
	endtask : rd
endmodule : rrir_host

// >>> sim/tb_raw_result_and_ident_regs.sv
// Self-checking bench for the raw result and identification bank.
`timescale 1ns/100ps

module tb_raw_result_and_ident_regs;
	import rrir_pkg::*;
	localparam logic [15:0] MK = 16'h5A3C; // Arbitrary maker value.
	localparam logic [15:0] PT = 16'h0F1E; // Arbitrary part value.
	localparam logic [63:0] DV = 64'hF0E1D2C3B4A59687; // Result pattern.
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, raw_upd = 1'b0, data_upd = 1'b0;
	logic [23:0] ch0 = 24'h0, ch2 = 24'h0, ch3 = 24'h0, v;
	logic [63:0] data = 64'h0;
	logic [5:0] gcode = 6'h00;
	logic [7:0] addr, rdata;
	logic rd, rvalid, ok;
	logic [11:0] gain;
	int error_cnt = 0, check_count = 0, cycles = 0;

	always #2.5 clk = ~clk;

	rrir_top #(.MAKER_CODE(MK), .PART_CODE(PT)) dut (.CLK_I(clk), .RESET_N_I(rst_n),
		.CE_I(ce), .REG_ADDR_I(addr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .RAW_UPD_I(raw_upd), .CH0_RAW_I(ch0), .CH2_RAW_I(ch2),
		.CH3_RAW_I(ch3), .DATA_UPD_I(data_upd), .DATA_I(data), .GAIN_CODE_I(gcode),
		.GAIN_FACTOR_O(gain));
	rrir_host host (.clk_i(clk), .rvalid_i(rvalid), .rdata_i(rdata), .addr_o(addr), .rd_o(rd));

	// Compare one result and count it.
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	// Read n bytes and compare both the answer strobe and the data.
	task automatic rdc(input logic [7:0] a, input int n, input logic [23:0] e);
		host.rd(a, n, v, ok);
		chk($sformatf("valid %h", a), 24'h1, {23'h0, ok});
		chk($sformatf("rdata %h", a), e, v);
	endtask : rdc

	// Gain in sixteenths: group base doubles, first step adds a sixteenth, later ones an eighth.
	function automatic logic [11:0] gexp(input int c);
		int g;
		int k;
		int b;
		g = c / 8;
		k = c % 8;
		b = 16 << g;
		if (k != 0) b = b + (1 << g) + (k - 1) * (2 << g);
		return 12'(b);
	endfunction : gexp

	// Verdict and end of run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	// Hang guard: the tests need well under a thousand cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rdc(RRIR_OFS_CH2_HIGH, 1, 24'h0);
		rdc(RRIR_OFS_CH3_LOW, 3, 24'h0);
		rdc(RRIR_OFS_CH0_LOW, 3, 24'h0);
		rdc(RRIR_OFS_MAKER_LOW, 2, {8'h0, MK});
		rdc(RRIR_OFS_PART_LOW, 2, {8'h0, PT});
		$display("reset values done");
		// Load raw words, then move the inputs so only the captured copy can match.
		@(posedge clk);
		raw_upd <= 1'b1;
		{ch0, ch2, ch3} <= {24'h123456, 24'hABCDEF, 24'h9A7B5C};
		@(posedge clk);
		raw_upd <= 1'b0;
		{ch0, ch2, ch3} <= ~{24'h123456, 24'hABCDEF, 24'h9A7B5C};
		rdc(RRIR_OFS_CH2_HIGH, 1, 24'h0000AB);
		rdc(RRIR_OFS_CH3_LOW, 3, 24'h9A7B5C);
		rdc(RRIR_OFS_CH0_LOW, 3, 24'h123456);
		$display("raw words done");
		// New words land on the middle read's edge: the burst must still
		// return the word of its low read, and the next burst the new word.
		fork
			host.rd(RRIR_OFS_CH0_LOW, 3, v, ok);
			begin
				repeat (2) @(posedge clk);
				raw_upd <= 1'b1;
				ch0 <= 24'h654321;
				@(posedge clk);
				raw_upd <= 1'b0;
			end
		join
		chk("burst valid", 24'h1, {23'h0, ok});
		chk("burst word", 24'h123456, v);
		rdc(RRIR_OFS_CH0_LOW, 3, 24'h654321);
		$display("burst coherence done");
		@(posedge clk);
		data_upd <= 1'b1;
		data <= DV;
		@(posedge clk);
		data_upd <= 1'b0;
		data <= ~DV;
		for (int i = 0; i < 8; i++) rdc(RRIR_OFS_DATA_FIRST + 8'(i), 1, {16'h0, DV[8*i +: 8]});
		rdc(RRIR_OFS_DATA_LAST + 8'h01, 1, 24'h0);
		$display("results done");
		// A strobe with the clock enable low must go unanswered.
		@(posedge clk);
		ce <= 1'b0;
		host.rd(RRIR_OFS_CH3_LOW, 1, v, ok);
		chk("ignored read", 24'h0, {23'h0, ok});
		@(posedge clk);
		ce <= 1'b1;
		for (int c = 0; c < 64; c++) begin
			@(posedge clk);
			gcode <= 6'(c);
			@(posedge clk);
			#1;
			chk($sformatf("gain %0d", c), {12'h0, gexp(c)}, {12'h0, gain});
		end
		$display("gain table done");
		close_out();
	end
endmodule : tb_raw_result_and_ident_regs
